// ---- design/fec_pkg.sv ----
/*
 * Constants for the feature enhancement control bank: register indices,
 * field positions, reset values and timing.
 * Assumes an 8-bit indexed register port on the system clock.
 */
package fec_pkg;
	localparam logic [7:0] IDX_FEAT_ONE   = 8'he0;
	localparam logic [7:0] IDX_FEAT_TWO   = 8'he1;
	localparam logic [7:0] IDX_FEAT_THREE = 8'he2;
	localparam logic [7:0] IDX_SLOT0_RNG  = 8'h26;
	localparam logic [7:0] IDX_SLOT1_RNG  = 8'h2c;
	localparam logic [7:0] IDX_SLOT0_BASE = 8'h2d;
	localparam logic [7:0] IDX_SLOT1_BASE = 8'h2e;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] TWO_WR_MASK    = 8'h1f;
	localparam logic [7:0] RNG_WR_MASK    = 8'hfb;
	localparam int B_TOP   = 7;
	localparam int B_SIX   = 6;
	localparam int B_FIVE  = 5;
	localparam int B_FOUR  = 4;
	localparam int B_THREE = 3;
	localparam int B_TWO   = 2;
	localparam int B_ONE   = 1;
	localparam int B_ZERO  = 0;
	localparam int MASK_LO = 3;
	localparam logic [2:0] DELAY_FAST_OFF = 3'h7;
	localparam int CLK_PERIOD_NS   = 50;
	localparam int WIDE_SAMPLE_NS  = 55;
	localparam int WIDE_SAMPLE_CYC = (WIDE_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SAMPLE_CNT_LAST = 2'(WIDE_SAMPLE_CYC);
	localparam int PANEL_OFF_DELAY_CYC = 4;
	localparam logic [2:0] PANEL_DELAY_INIT = 3'h0;
endpackage : fec_pkg

// ---- design/fec_window_match.sv ----
/*
 * One card slot I/O window comparator with 8-byte-granular masking.
 * Assumes address, cycle and window fields are in the system clock domain.
 */
module fec_window_match (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [7:0] range_reg,
	input  wire logic [7:0] base_reg,
	input  wire logic       window_gate,
	input  wire logic [7:0] io_addr,
	input  wire logic       io_cycle,
	output logic            window_hit
);
	logic [7:0] care_bits;
	logic       hit_now;
	logic       window_on;
	logic       hit_r;

	// Low three address bits never compared: 8-byte minimum window
	assign care_bits = {~range_reg[7:fec_pkg::MASK_LO], 3'h0};
	assign window_on = range_reg[fec_pkg::B_ONE] & window_gate;
	assign hit_now   = io_cycle & window_on &
			(((io_addr ^ base_reg) & care_bits) == 8'h00);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			hit_r <= 1'b0;
		end else begin
			hit_r <= hit_now;
		end
	end
	assign window_hit = hit_r;

	a_hit_masked : assert property (@(posedge clk_sys) disable iff (reset)
		hit_r |-> $past(window_on) && $past(io_cycle))
		else $error("window hit without enabled window");
endmodule : fec_window_match

// ---- design/fec_bank.sv ----
/*
 * Feature enhancement control bank: three feature-enable registers, two
 * slot I/O range registers and window bases, plus the gating they apply.
 * Assumes card, UART, panel and power state signals are synchronous to
 * clk_sys except the card acknowledge and width lines, which are pins.
 */
// The strobed register port was decided locally.
module fec_bank (
	input  wire logic       clk_sys,
	input  wire logic       reset,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] io_addr,
	input  wire logic       io_cycle,
	input  wire logic [1:0] card_select,
	input  wire logic [1:0] card_input_ack_pin,
	input  wire logic [1:0] card_wide_io_pin,
	output logic      [1:0] card_buffer_on,
	output logic      [1:0] card_wide_io,
	output logic      [1:0] window_hit,
	output logic      [1:0] global_mask_active,
	input  wire logic       doze_request,
	input  wire logic       sleep_request,
	input  wire logic       rom_select_zero,
	input  wire logic       rom_select_one,
	output logic            cpu_clock_stop,
	output logic            clock_stopped_doze,
	output logic            data_input_gate,
	input  wire logic       uart_rate_clock,
	input  wire logic       pin_three_mode_out,
	input  wire logic       pin_three_mode_oe_n,
	input  wire logic       suspend_or_off,
	output logic            general_pin_three_out,
	output logic            general_pin_three_oe_n,
	input  wire logic       hw_panel_logic_power,
	input  wire logic       hw_panel_signals,
	input  wire logic       hw_panel_bias_power,
	input  wire logic [2:0] panel_power_delay,
	output logic            panel_logic_power_out,
	output logic            panel_logic_power_oe_n,
	output logic            panel_signals_on,
	output logic            panel_bias_power_out,
	output logic            panel_bias_power_oe_n,
	output logic            panel_fast_off,
	output logic            arbiter_reset,
	output logic            suspend_start_delay,
	output logic            lcd_cycle_stretch,
	output logic            narrow_card_support,
	output logic            card_change_extras,
	output logic            attr_memory_extra,
	output logic            presence_report_extra,
	output logic            wide_dram_suspend_fix,
	output logic            narrow_pseudo_sram_fix
);
	logic [7:0] feat_one_r;
	logic [7:0] feat_two_r;
	logic [7:0] feat_three_r;
	logic [7:0] range_r [2];
	logic [7:0] base_r [2];
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       arb_pulse_r;
	logic [1:0] ack_s1_r;
	logic [1:0] ack_s2_r;
	logic [1:0] wide_s1_r;
	logic [1:0] wide_s2_r;
	logic [1:0] wide_r;
	logic [1:0] sel_d_r;
	logic [1:0] samp_cnt_r [2];
	logic       doze_stop_r;
	logic       rom_busy;
	logic       master_feature_on;
	logic       third_on;
	logic       global_mask_on;
	logic       slow_disk_sampling;
	logic       rom_select_doze_guard;
	logic       manual_seq;
	logic       fast_panel;
	logic       baud_sel;
	logic       doze_want;
	logic       wr_one;
	logic       wr_two;
	logic       wr_three;
	logic [1:0] wr_rng;
	logic [1:0] wr_base;

	assign wr_one   = reg_wr & (reg_addr == fec_pkg::IDX_FEAT_ONE);
	assign wr_two   = reg_wr & (reg_addr == fec_pkg::IDX_FEAT_TWO);
	assign wr_three = reg_wr & (reg_addr == fec_pkg::IDX_FEAT_THREE);
	assign wr_rng   = {reg_wr & (reg_addr == fec_pkg::IDX_SLOT1_RNG),
			reg_wr & (reg_addr == fec_pkg::IDX_SLOT0_RNG)};
	assign wr_base  = {reg_wr & (reg_addr == fec_pkg::IDX_SLOT1_BASE),
			reg_wr & (reg_addr == fec_pkg::IDX_SLOT0_BASE)};

	// Stored values land on the write edge, used from the next cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			feat_one_r   <= fec_pkg::REG_RESET;
			feat_two_r   <= fec_pkg::REG_RESET;
			feat_three_r <= fec_pkg::REG_RESET;
			arb_pulse_r  <= 1'b0;
		end else begin
			if (wr_one)
				feat_one_r <= reg_wdata;
			if (wr_two)
				feat_two_r <= reg_wdata & fec_pkg::TWO_WR_MASK;
			if (wr_three)
				feat_three_r <= reg_wdata;
			arb_pulse_r <= wr_three & reg_wdata[fec_pkg::B_FOUR];
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			unique case (reg_addr)
				fec_pkg::IDX_FEAT_ONE:   rdata_nxt = feat_one_r;
				fec_pkg::IDX_FEAT_TWO:   rdata_nxt = feat_two_r;
				fec_pkg::IDX_FEAT_THREE: rdata_nxt = feat_three_r;
				fec_pkg::IDX_SLOT0_RNG:  rdata_nxt = range_r[0];
				fec_pkg::IDX_SLOT1_RNG:  rdata_nxt = range_r[1];
				fec_pkg::IDX_SLOT0_BASE: rdata_nxt = base_r[0];
				fec_pkg::IDX_SLOT1_BASE: rdata_nxt = base_r[1];
				default:                 rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_r <= 8'h00;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end
	assign reg_rdata = rdata_r;

	// Master enable gating
	assign master_feature_on     = feat_one_r[fec_pkg::B_TOP];
	assign third_on              = master_feature_on & feat_three_r[fec_pkg::B_TOP];
	assign suspend_start_delay   = master_feature_on & feat_one_r[fec_pkg::B_SIX];
	assign lcd_cycle_stretch     = master_feature_on & feat_one_r[fec_pkg::B_FIVE];
	assign narrow_card_support   = master_feature_on & feat_one_r[fec_pkg::B_FOUR];
	assign card_change_extras    = master_feature_on & feat_one_r[fec_pkg::B_THREE];
	assign attr_memory_extra     = master_feature_on & feat_one_r[fec_pkg::B_TWO];
	assign presence_report_extra = master_feature_on & feat_one_r[fec_pkg::B_ONE];
	assign wide_dram_suspend_fix = master_feature_on & feat_one_r[fec_pkg::B_ZERO];
	assign narrow_pseudo_sram_fix = master_feature_on & feat_two_r[fec_pkg::B_THREE];
	assign rom_select_doze_guard = master_feature_on & feat_two_r[fec_pkg::B_TWO];
	assign slow_disk_sampling    = master_feature_on & feat_two_r[fec_pkg::B_ONE];
	assign global_mask_on        = master_feature_on & feat_two_r[fec_pkg::B_ZERO];
	assign manual_seq            = third_on & feat_three_r[fec_pkg::B_THREE];
	assign fast_panel            = third_on & feat_three_r[fec_pkg::B_SIX];
	assign baud_sel              = third_on & feat_three_r[fec_pkg::B_FIVE];
	assign arbiter_reset         = third_on & arb_pulse_r;

	// Pins cross two flops before use
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ack_s1_r  <= 2'h0;
			ack_s2_r  <= 2'h0;
			wide_s1_r <= 2'h0;
			wide_s2_r <= 2'h0;
			sel_d_r   <= 2'h0;
		end else begin
			ack_s1_r  <= card_input_ack_pin;
			ack_s2_r  <= ack_s1_r;
			wide_s1_r <= card_wide_io_pin;
			wide_s2_r <= wide_s1_r;
			sel_d_r   <= card_select;
		end
	end

	// Slow sampling: select rises and stays up one more edge before the take
	sequence s_slow_select(sel, sel_d);
		slow_disk_sampling && sel && !sel_d ##1 slow_disk_sampling && sel;
	endsequence

	genvar s;
	generate
		for (s = 0; s < 2; s++) begin : g_slot
			logic ack_gate;
			logic sel_rise;
			assign ack_gate = range_r[s][fec_pkg::B_ZERO];
			assign card_buffer_on[s] = card_select[s] &
					(~ack_gate | ack_s2_r[s]);
			assign global_mask_active[s] = global_mask_on &
					base_r[s][fec_pkg::B_ZERO];
			assign sel_rise = card_select[s] & ~sel_d_r[s];

			always_ff @(posedge clk_sys) begin
				if (reset) begin
					range_r[s] <= fec_pkg::REG_RESET;
					base_r[s]  <= fec_pkg::REG_RESET;
				end else begin
					if (wr_rng[s])
						range_r[s] <= reg_wdata & fec_pkg::RNG_WR_MASK;
					if (wr_base[s])
						base_r[s] <= reg_wdata;
				end
			end

			// Legacy mode samples at select; slow mode waits 55 ns rounded up to 2 clocks (100 ns)
			always_ff @(posedge clk_sys) begin
				if (reset) begin
					samp_cnt_r[s] <= 2'h0;
					wide_r[s]     <= 1'b0;
				end else if (!card_select[s]) begin
					samp_cnt_r[s] <= 2'h0;
				end else if (sel_rise && !slow_disk_sampling) begin
					wide_r[s] <= wide_s2_r[s];
				end else if (slow_disk_sampling &&
						samp_cnt_r[s] != fec_pkg::SAMPLE_CNT_LAST) begin
					samp_cnt_r[s] <= samp_cnt_r[s] + 2'h1;
					if (samp_cnt_r[s] + 2'h1 == fec_pkg::SAMPLE_CNT_LAST)
						wide_r[s] <= wide_s2_r[s];
				end
			end
			assign card_wide_io[s] = wide_r[s];

			fec_window_match u_match (
				.clk_sys     (clk_sys),
				.reset       (reset),
				.range_reg   (range_r[s]),
				.base_reg    (base_r[s]),
				.window_gate (global_mask_on),
				.io_addr     (io_addr),
				.io_cycle    (io_cycle),
				.window_hit  (window_hit[s])
			);

			a_buffer_gate : assert property (@(posedge clk_sys) disable iff (reset)
				card_buffer_on[s] |-> card_select[s])
				else $error("card buffer on without select");
			a_ack_bypass : assert property (@(posedge clk_sys) disable iff (reset)
				!ack_gate |-> card_buffer_on[s] == card_select[s])
				else $error("card buffer not following select");
			a_ack_wait : assert property (@(posedge clk_sys) disable iff (reset)
				ack_gate && !ack_s2_r[s] |-> !card_buffer_on[s])
				else $error("card buffer on without acknowledge");
			// Synced level one edge late, so a slow card has settled
			a_slow_latch : assert property (@(posedge clk_sys) disable iff (reset)
				s_slow_select(card_select[s], sel_d_r[s]) |=> wide_r[s] == $past(wide_s2_r[s]))
				else $error("slow width sample not taken");
		end
	endgenerate

	// Doze entry waits for both ROM selects idle when guarded
	assign rom_busy  = rom_select_zero | rom_select_one;
	assign doze_want = doze_request | sleep_request;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			doze_stop_r <= 1'b0;
		end else if (!doze_want) begin
			doze_stop_r <= 1'b0;
		end else if (!(rom_select_doze_guard && rom_busy)) begin
			doze_stop_r <= 1'b1;
		end
	end
	assign cpu_clock_stop     = doze_stop_r;
	assign clock_stopped_doze = doze_stop_r;
	assign data_input_gate    = doze_stop_r & master_feature_on &
			feat_two_r[fec_pkg::B_FOUR];

	// Pin three: suspend float wins over baud override
	assign general_pin_three_out  = baud_sel ? uart_rate_clock : pin_three_mode_out;
	assign general_pin_three_oe_n = suspend_or_off ? 1'b1 :
			(baud_sel ? 1'b0 : pin_three_mode_oe_n);

	// Panel power: manual bits or hardware sequencer
	assign panel_fast_off = fast_panel & ~manual_seq &
			(panel_power_delay == fec_pkg::DELAY_FAST_OFF);
	assign panel_logic_power_out  = 1'b1;
	assign panel_bias_power_out   = 1'b1;
	assign panel_logic_power_oe_n = manual_seq ? ~feat_three_r[fec_pkg::B_TWO] :
			~(hw_panel_logic_power & ~panel_fast_off);
	assign panel_bias_power_oe_n  = manual_seq ? ~feat_three_r[fec_pkg::B_ZERO] :
			~(hw_panel_bias_power & ~panel_fast_off);
	assign panel_signals_on = manual_seq ? feat_three_r[fec_pkg::B_ONE] :
			(hw_panel_signals & ~panel_fast_off);

	// Doze request with no guarded ROM select pending
	sequence s_doze_clear;
		doze_want && !(rom_select_doze_guard && rom_busy);
	endsequence

	a_pin_float : assert property (@(posedge clk_sys) disable iff (reset)
		suspend_or_off |-> general_pin_three_oe_n)
		else $error("pin three driven in suspend");
	a_baud_drive : assert property (@(posedge clk_sys) disable iff (reset)
		(baud_sel && !suspend_or_off) |-> !general_pin_three_oe_n &&
			general_pin_three_out == uart_rate_clock)
		else $error("baud clock not on pin three");
	a_doze_rom : assert property (@(posedge clk_sys) disable iff (reset)
		$rose(doze_stop_r) && $past(rom_select_doze_guard) |-> !$past(rom_busy))
		else $error("doze entered with rom selected");
	a_doze_enter : assert property (@(posedge clk_sys) disable iff (reset)
		s_doze_clear |=> cpu_clock_stop && clock_stopped_doze)
		else $error("processor clock not stopped in doze");
	a_master_gate : assert property (@(posedge clk_sys) disable iff (reset)
		!feat_one_r[fec_pkg::B_TOP] |-> !suspend_start_delay && !panel_fast_off &&
			!data_input_gate && !arbiter_reset)
		else $error("feature active without master");
	// Local enable comes from the same write, so look at the written byte
	a_arb_pulse : assert property (@(posedge clk_sys) disable iff (reset)
		(wr_three && reg_wdata[fec_pkg::B_FOUR] && reg_wdata[fec_pkg::B_TOP] &&
			master_feature_on) |=> arbiter_reset)
		else $error("arbiter reset missing");
	a_write_take : assert property (@(posedge clk_sys) disable iff (reset)
		wr_one |=> feat_one_r == $past(reg_wdata))
		else $error("bank one write lost");
	a_manual_sig : assert property (@(posedge clk_sys) disable iff (reset)
		manual_seq |-> panel_signals_on == feat_three_r[fec_pkg::B_ONE] &&
			panel_logic_power_oe_n == !feat_three_r[fec_pkg::B_TWO])
		else $error("manual panel control ignored");
	a_bias_float : assert property (@(posedge clk_sys) disable iff (reset)
		manual_seq && !feat_three_r[fec_pkg::B_ZERO] |-> panel_bias_power_oe_n)
		else $error("bias power driven while off");
	a_fast_dark : assert property (@(posedge clk_sys) disable iff (reset)
		panel_fast_off |-> panel_logic_power_oe_n && panel_bias_power_oe_n &&
			!panel_signals_on)
		else $error("panel still powered in fast off");
	a_two_rsvd : assert property (@(posedge clk_sys) disable iff (reset)
		feat_two_r[7:5] == 3'h0)
		else $error("reserved bits set");
endmodule : fec_bank

// ---- dv/fec_bank_tb_top.sv ----
/* Self-checking bench for fec_bank: register access, gating, pin overrides.
 * Assumes the bank stands alone on clk_sys; the bench drives every pin. */
module fec_bank_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk_sys, reset, reg_wr, reg_rd, io_cycle, doze_request, sleep_request;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, io_addr;
	logic [1:0] card_select, card_input_ack_pin, card_wide_io_pin, card_buffer_on;
	logic [1:0] card_wide_io, window_hit, global_mask_active;
	logic       rom_select_zero, rom_select_one, cpu_clock_stop, clock_stopped_doze;
	logic       data_input_gate, uart_rate_clock, pin_three_mode_out, pin_three_mode_oe_n;
	logic       suspend_or_off, general_pin_three_out, general_pin_three_oe_n;
	logic       hw_panel_logic_power, hw_panel_signals, hw_panel_bias_power;
	logic [2:0] panel_power_delay;
	logic       panel_logic_power_out, panel_logic_power_oe_n, panel_signals_on;
	logic       panel_bias_power_out, panel_bias_power_oe_n, panel_fast_off;
	logic       arbiter_reset, narrow_pseudo_sram_fix;
	logic [6:0] feat_out;
	logic [2:0] panel;
	int         error_cnt, tests_run;
	localparam logic [7:0] IDX [8] = '{fec_pkg::IDX_FEAT_ONE, fec_pkg::IDX_FEAT_TWO,
		fec_pkg::IDX_FEAT_THREE, fec_pkg::IDX_SLOT0_RNG, fec_pkg::IDX_SLOT1_RNG,
		fec_pkg::IDX_SLOT0_BASE, fec_pkg::IDX_SLOT1_BASE, 8'h55};
	localparam logic [7:0] RBK [7] = '{8'hff, fec_pkg::TWO_WR_MASK, 8'hff,
		fec_pkg::RNG_WR_MASK, fec_pkg::RNG_WR_MASK, 8'hff, 8'hff};

	assign panel = {panel_logic_power_oe_n, panel_signals_on, panel_bias_power_oe_n};

	fec_bank i_fec_bank (
		.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .io_addr(io_addr),
		.io_cycle(io_cycle), .card_select(card_select),
		.card_input_ack_pin(card_input_ack_pin), .card_wide_io_pin(card_wide_io_pin),
		.card_buffer_on(card_buffer_on), .card_wide_io(card_wide_io),
		.window_hit(window_hit), .global_mask_active(global_mask_active),
		.doze_request(doze_request), .sleep_request(sleep_request),
		.rom_select_zero(rom_select_zero), .rom_select_one(rom_select_one),
		.cpu_clock_stop(cpu_clock_stop), .clock_stopped_doze(clock_stopped_doze),
		.data_input_gate(data_input_gate), .uart_rate_clock(uart_rate_clock),
		.pin_three_mode_out(pin_three_mode_out),
		.pin_three_mode_oe_n(pin_three_mode_oe_n),
		.suspend_or_off(suspend_or_off), .general_pin_three_out(general_pin_three_out),
		.general_pin_three_oe_n(general_pin_three_oe_n),
		.hw_panel_logic_power(hw_panel_logic_power), .hw_panel_signals(hw_panel_signals),
		.hw_panel_bias_power(hw_panel_bias_power), .panel_power_delay(panel_power_delay),
		.panel_logic_power_out(panel_logic_power_out),
		.panel_logic_power_oe_n(panel_logic_power_oe_n), .panel_signals_on(panel_signals_on),
		.panel_bias_power_out(panel_bias_power_out),
		.panel_bias_power_oe_n(panel_bias_power_oe_n), .panel_fast_off(panel_fast_off),
		.arbiter_reset(arbiter_reset), .suspend_start_delay(feat_out[6]),
		.lcd_cycle_stretch(feat_out[5]), .narrow_card_support(feat_out[4]),
		.card_change_extras(feat_out[3]), .attr_memory_extra(feat_out[2]),
		.presence_report_extra(feat_out[1]), .wide_dram_suspend_fix(feat_out[0]),
		.narrow_pseudo_sram_fix(narrow_pseudo_sram_fix)
	);

	always #25 clk_sys = ~clk_sys;

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= v;
		reg_wr    <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rdchk

	// Hit is registered, so look one edge after the address goes out
	task win(input logic [7:0] a, input logic [1:0] e);
		@(posedge clk_sys);
		io_addr  <= a;
		io_cycle <= 1'b1;
		@(posedge clk_sys);
		#1;
		chk(8'(window_hit), 8'(e));
	endtask : win

	task tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task test_done;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done

	// Whole run is well under a thousand cycles
	initial begin
		#(50 * 4000);
		error_cnt++;
		test_done();
	end

	initial begin
		{clk_sys, reg_wr, reg_rd, io_cycle, doze_request, sleep_request} = '0;
		{reg_addr, reg_wdata, io_addr, card_select, card_input_ack_pin} = '0;
		{card_wide_io_pin, rom_select_zero, rom_select_one, uart_rate_clock} = '0;
		{suspend_or_off, pin_three_mode_out, panel_power_delay} = '0;
		{hw_panel_logic_power, hw_panel_signals, hw_panel_bias_power} = 3'h7;
		pin_three_mode_oe_n = 1'b1;
		reset = 1'b1;
		error_cnt = 0;
		tests_run = 0;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		foreach (IDX[k]) rdchk(IDX[k], fec_pkg::REG_RESET);
		wr(IDX[2], 8'h7f);
		wr(IDX[1], 8'h1f);
		chk({arbiter_reset, general_pin_three_oe_n, data_input_gate}, 8'h02);
		chk(8'(narrow_pseudo_sram_fix), 8'h00);
		wr(IDX[0], 8'h80);
		wr(IDX[2], 8'h7f);
		chk({arbiter_reset, general_pin_three_oe_n, panel}, 8'h0a);
		wr(IDX[1], 8'h00);
		for (int b = 0; b < 7; b++) begin
			wr(IDX[0], 8'h80 | (8'h01 << b));
			chk(8'(feat_out), 8'h01 << b);
		end
		wr(IDX[0], 8'h80);
		wr(IDX[1], 8'h08);
		chk(8'(narrow_pseudo_sram_fix), 8'h01);
		wr(IDX[2], 8'h90);
		chk(8'(arbiter_reset), 8'h01);
		tick(1);
		chk(8'(arbiter_reset), 8'h00);
		wr(IDX[2], 8'h80);
		chk(8'(arbiter_reset), 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(IDX[2], 8'h88 | 8'(i));
			chk(8'(panel), 8'(i ^ 5));
		end
		chk({panel_logic_power_out, panel_bias_power_out}, 8'h03);
		wr(IDX[2], 8'hc0);
		@(posedge clk_sys);
		panel_power_delay <= fec_pkg::DELAY_FAST_OFF;
		#1;
		chk({panel_fast_off, panel}, 8'h0d);
		@(posedge clk_sys);
		panel_power_delay <= 3'h3;
		#1;
		chk({panel_fast_off, panel}, 8'h02);
		// Baud override, then suspend must still float the pin
		wr(IDX[2], 8'ha0);
		@(posedge clk_sys);
		uart_rate_clock <= 1'b1;
		#1;
		chk({general_pin_three_out, general_pin_three_oe_n}, 8'h02);
		@(posedge clk_sys);
		uart_rate_clock <= 1'b0;
		pin_three_mode_out <= 1'b1;
		#1;
		chk({general_pin_three_out, general_pin_three_oe_n}, 8'h00);
		@(posedge clk_sys);
		suspend_or_off <= 1'b1;
		#1;
		chk(8'(general_pin_three_oe_n), 8'h01);
		suspend_or_off <= 1'b0;
		wr(IDX[1], 8'h01);
		wr(IDX[5], 8'h41);
		chk(8'(global_mask_active), 8'h01);
		wr(IDX[3], 8'h02);
		win(8'h47, 2'b01);
		win(8'h48, 2'b00);
		win(8'h3f, 2'b00);
		wr(IDX[3], 8'h0a);
		win(8'h4f, 2'b01);
		win(8'h50, 2'b00);
		wr(IDX[3], 8'hfa);
		win(8'hc5, 2'b01);
		wr(IDX[1], 8'h00);
		win(8'h41, 2'b00);
		chk(8'(global_mask_active), 8'h00);
		@(posedge clk_sys);
		io_cycle    <= 1'b0;
		card_select <= 2'b01;
		#1;
		chk(8'(card_buffer_on), 8'h01);
		wr(IDX[3], 8'h0b);
		chk(8'(card_buffer_on), 8'h00);
		@(posedge clk_sys);
		card_input_ack_pin <= 2'b01;
		tick(3);
		chk(8'(card_buffer_on), 8'h01);
		wr(IDX[1], 8'h02);
		@(posedge clk_sys);
		card_select      <= 2'b00;
		card_wide_io_pin <= 2'b11;
		tick(3);
		card_select <= 2'b10;
		tick(4);
		chk(8'(card_wide_io[1]), 8'h01);
		card_select <= 2'b00;
		// Guard holds the clock while a ROM select is still active
		wr(IDX[1], 8'h14);
		// Slow sampling now off: slot 0 takes its width at the select edge
		@(posedge clk_sys);
		card_select <= 2'b01;
		tick(2);
		chk(8'(card_wide_io), 8'h03);
		card_select <= 2'b00;
		@(posedge clk_sys);
		rom_select_zero <= 1'b1;
		doze_request    <= 1'b1;
		tick(4);
		chk(8'(cpu_clock_stop), 8'h00);
		rom_select_zero <= 1'b0;
		tick(2);
		chk({cpu_clock_stop, clock_stopped_doze, data_input_gate}, 8'h07);
		doze_request <= 1'b0;
		tick(2);
		chk(8'(cpu_clock_stop), 8'h00);
		wr(IDX[1], 8'h00);
		@(posedge clk_sys);
		rom_select_one <= 1'b1;
		sleep_request  <= 1'b1;
		tick(2);
		chk(8'(cpu_clock_stop), 8'h01);
		sleep_request <= 1'b0;
		for (int k = 0; k < 7; k++) wr(IDX[k], 8'hff);
		for (int k = 0; k < 7; k++) rdchk(IDX[k], RBK[k]);
		@(posedge clk_sys);
		reset <= 1'b1;
		tick(2);
		reset <= 1'b0;
		foreach (IDX[k]) rdchk(IDX[k], fec_pkg::REG_RESET);
		chk({arbiter_reset, data_input_gate, 6'(feat_out)}, 8'h00);
		test_done();
	end
endmodule : fec_bank_tb_top
